// *** logic/pca_pkg.sv ***
package pca_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_MODE_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RUN_FLAGS = 8'h04;
  localparam logic [7:0] OFS_MODE_BASE = 8'h10;
  localparam logic [7:0] OFS_VAL_LO_BASE = 8'h30;
  localparam logic [7:0] OFS_VAL_HI_BASE = 8'h50;
  localparam logic [7:0] OFS_COUNT_LO = 8'h70;
  localparam logic [7:0] OFS_COUNT_HI = 8'h74;
  localparam logic [7:0] OFS_CLOCK_MODE = 8'h78;
  localparam int unsigned REG_STRIDE = 4;

  // Field positions in pca_mode_config.
  localparam int unsigned CFG_IDLE_STOP = 7;
  localparam int unsigned CFG_WATCHDOG_ENABLE = 6;
  localparam int unsigned CFG_SRC_HI = 2;
  localparam int unsigned CFG_SRC_LO = 1;
  localparam int unsigned CFG_OVF_IRQ_ENABLE = 0;

  // Field positions in pca_run_and_flags.
  localparam int unsigned RF_OVERFLOW_FLAG = 7;
  localparam int unsigned RF_RUN_CONTROL = 6;

  // Field positions in module_mode_control.
  localparam int unsigned MM_IRQ_ENABLE = 0;
  localparam int unsigned MM_PWM = 1;
  localparam int unsigned MM_TOGGLE = 2;
  localparam int unsigned MM_FLAG_ON_MATCH = 3;
  localparam int unsigned MM_CAPTURE_FALLING = 4;
  localparam int unsigned MM_CAPTURE_RISING = 5;
  localparam int unsigned MM_COMPARATOR_ENABLE = 6;

  // Reset values.
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic RST_PIN_LEVEL = 1'b1;

  // Count source encodings.
  localparam logic [1:0] SRC_OSC_SLOW = 2'h0;
  localparam logic [1:0] SRC_OSC_FAST = 2'h1;
  localparam logic [1:0] SRC_TIMER0 = 2'h2;
  localparam logic [1:0] SRC_EXT_PIN = 2'h3;

  // Oscillator divide ratios of the two internal count sources.
  localparam logic [3:0] DIV_SLOW_6CLK = 4'h6;
  localparam logic [3:0] DIV_SLOW_12CLK = 4'hc;
  localparam logic [3:0] DIV_FAST_6CLK = 4'h2;
  localparam logic [3:0] DIV_FAST_12CLK = 4'h4;

endpackage : pca_pkg

// *** logic/programmable_counter_array.sv ***
module programmable_counter_array
  import pca_pkg::*;
#(
  parameter int NUM_MODULES = 5,
  parameter int WDT_MODULE = 4
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic idle_mode,
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  input wire logic [NUM_MODULES-1:0] module_pin_in,
  output logic [NUM_MODULES-1:0] module_pin_out,
  output logic [NUM_MODULES-1:0] module_pin_oe_n,
  output logic irq,
  output logic watchdog_reset
);

  // Bus state.
  logic wr_ff;
  logic [7:0] waddr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [31:0] nxt_rdata;

  // Control and status.
  logic [7:0] cfg_ff;
  logic clk12_ff, run_ff, ovf_ff;
  logic [NUM_MODULES-1:0] evt_ff;
  logic [7:0] mode_ff [NUM_MODULES];
  logic [7:0] vlo_ff [NUM_MODULES];
  logic [7:0] vhi_ff [NUM_MODULES];
  logic [15:0] count_ff;
  logic [3:0] pre_ff;
  logic [NUM_MODULES-1:0] pin_out_ff;
  logic [NUM_MODULES-1:0] pin_oe_n_ff;
  logic irq_ff, wdt_ff;

  // Synchronisers for pins from outside the clock domain.
  logic [NUM_MODULES-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
  logic eci_s1_ff, eci_s2_ff, eci_s3_ff;

  // Picks the prescaler divide ratio for an internal source.
  function automatic logic [3:0] div_of(input logic [1:0] src, input logic clk12);
    if (src == SRC_OSC_SLOW)
    begin
      return clk12 ? DIV_SLOW_12CLK : DIV_SLOW_6CLK;
    end
    return clk12 ? DIV_FAST_12CLK : DIV_FAST_6CLK;
  endfunction : div_of

  // Address phase accept and data phase write decode.
  wire addr_phase_w = hsel && htrans[1] && hready;
  wire cfg_we_w = wr_ff && (waddr_ff == OFS_MODE_CONFIG);
  wire rf_we_w = wr_ff && (waddr_ff == OFS_RUN_FLAGS);
  wire cnt_lo_we_w = wr_ff && (waddr_ff == OFS_COUNT_LO);
  wire cnt_hi_we_w = wr_ff && (waddr_ff == OFS_COUNT_HI);
  wire clk_we_w = wr_ff && (waddr_ff == OFS_CLOCK_MODE);
  wire [7:0] wbyte_w = hwdata[7:0];

  // Count source, run gating and prescaler.
  wire [1:0] src_w = {cfg_ff[CFG_SRC_HI], cfg_ff[CFG_SRC_LO]};
  wire run_w = run_ff && !(cfg_ff[CFG_IDLE_STOP] && idle_mode);
  wire [3:0] div_w = div_of(src_w, clk12_ff);
  wire pre_done_w = pre_ff >= (div_w - 4'h1);
  wire eci_rise_w = eci_s2_ff && !eci_s3_ff;
  wire tick_w = run_w && ((src_w == SRC_TIMER0) ? timer0_overflow :
                (src_w == SRC_EXT_PIN) ? eci_rise_w : pre_done_w);
  wire [15:0] nxt_count_w = count_ff + 16'h0001;
  wire ovf_set_w = tick_w && (count_ff == 16'hffff);

  // Per-module decode, match, capture and pin behaviour.
  logic [NUM_MODULES-1:0] mode_we_w;
  logic [NUM_MODULES-1:0] vlo_we_w;
  logic [NUM_MODULES-1:0] vhi_we_w;
  logic [NUM_MODULES-1:0] match_w;
  logic [NUM_MODULES-1:0] cap_w;
  logic [NUM_MODULES-1:0] evt_set_w;
  logic [NUM_MODULES-1:0] irq_en_w;
  logic [NUM_MODULES-1:0] pwm_lvl_w;
  logic [NUM_MODULES-1:0] drive_w;
  logic [NUM_MODULES-1:0] nxt_pin;
  logic [NUM_MODULES-1:0] pin_rise_w;
  logic [NUM_MODULES-1:0] pin_fall_w;

  for (genvar n = 0; n < NUM_MODULES; n++)
  begin : g_mod
    localparam logic [7:0] A_MODE = 8'(OFS_MODE_BASE + REG_STRIDE * n);
    localparam logic [7:0] A_VLO = 8'(OFS_VAL_LO_BASE + REG_STRIDE * n);
    localparam logic [7:0] A_VHI = 8'(OFS_VAL_HI_BASE + REG_STRIDE * n);
    wire comp_w = mode_ff[n][MM_COMPARATOR_ENABLE];
    wire pwm_w = mode_ff[n][MM_PWM];
    assign mode_we_w[n] = wr_ff && (waddr_ff == A_MODE);
    assign vlo_we_w[n] = wr_ff && (waddr_ff == A_VLO);
    assign vhi_we_w[n] = wr_ff && (waddr_ff == A_VHI);
    assign pin_rise_w[n] = pin_s2_ff[n] && !pin_s3_ff[n];
    assign pin_fall_w[n] = !pin_s2_ff[n] && pin_s3_ff[n];
    // The match fires once, as the shared counter steps onto the value.
    assign match_w[n] = tick_w && comp_w && !pwm_w &&
                        (nxt_count_w == {vhi_ff[n], vlo_ff[n]});
    assign cap_w[n] = (mode_ff[n][MM_CAPTURE_RISING] && pin_rise_w[n]) ||
                      (mode_ff[n][MM_CAPTURE_FALLING] && pin_fall_w[n]);
    assign evt_set_w[n] = cap_w[n] || (match_w[n] && mode_ff[n][MM_FLAG_ON_MATCH]);
    assign irq_en_w[n] = mode_ff[n][MM_IRQ_ENABLE];
    assign pwm_lvl_w[n] = count_ff[7:0] >= vlo_ff[n];
    assign drive_w[n] = comp_w && (pwm_w || mode_ff[n][MM_TOGGLE]);
    assign nxt_pin[n] = (comp_w && pwm_w) ? pwm_lvl_w[n] :
                        (match_w[n] && mode_ff[n][MM_TOGGLE]) ? !pin_out_ff[n] :
                        pin_out_ff[n];

    // Next values: capture wins over a bus write; PWM reloads low from high.
    wire reload_w = pwm_w && tick_w && (count_ff[7:0] == 8'hff);
    wire [7:0] nxt_lo = vlo_we_w[n] ? wbyte_w : (reload_w ? vhi_ff[n] : vlo_ff[n]);
    wire [7:0] nxt_hi = vhi_we_w[n] ? wbyte_w : vhi_ff[n];
    wire [15:0] nxt_val = cap_w[n] ? count_ff : {nxt_hi, nxt_lo};
    wire [7:0] nxt_mode = mode_we_w[n] ? {1'b0, wbyte_w[6:0]} : mode_ff[n];

    // Value and mode registers of the module.
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        vlo_ff[n] <= RST_REG8;
        vhi_ff[n] <= RST_REG8;
        mode_ff[n] <= RST_REG8;
      end
      else
      begin
        {vhi_ff[n], vlo_ff[n]} <= nxt_val;
        mode_ff[n] <= nxt_mode;
      end
    end
  end

  // Read data multiplexer; unmapped offsets read zero.
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (haddr[7:0])
      OFS_MODE_CONFIG: nxt_rdata[7:0] = cfg_ff;
      OFS_RUN_FLAGS: nxt_rdata[7:0] = 8'({ovf_ff, run_ff, 1'b0, 5'(evt_ff)});
      OFS_COUNT_LO: nxt_rdata[7:0] = count_ff[7:0];
      OFS_COUNT_HI: nxt_rdata[7:0] = count_ff[15:8];
      OFS_CLOCK_MODE: nxt_rdata[0] = clk12_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
    for (int i = 0; i < NUM_MODULES; i++)
    begin
      if (haddr[7:0] == 8'(OFS_MODE_BASE + REG_STRIDE * i))
      begin
        nxt_rdata[7:0] = mode_ff[i];
      end
      if (haddr[7:0] == 8'(OFS_VAL_LO_BASE + REG_STRIDE * i))
      begin
        nxt_rdata[7:0] = vlo_ff[i];
      end
      if (haddr[7:0] == 8'(OFS_VAL_HI_BASE + REG_STRIDE * i))
      begin
        nxt_rdata[7:0] = vhi_ff[i];
      end
    end
  end

  // Bus slave: zero wait states, read data captured in the address phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ff <= 1'b0;
      waddr_ff <= RST_REG8;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      hresp_ff <= 1'b0;
    end
    else
    begin
      wr_ff <= addr_phase_w && hwrite;
      waddr_ff <= haddr[7:0];
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      if (addr_phase_w && !hwrite)
      begin
        hrdata_ff <= nxt_rdata;
      end
    end
  end

  // Configuration and run control written by software.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_ff <= RST_REG8;
      clk12_ff <= 1'b0;
      run_ff <= 1'b0;
    end
    else
    begin
      if (cfg_we_w)
      begin
        cfg_ff <= {wbyte_w[7:6], 3'h0, wbyte_w[2:0]};
      end
      if (clk_we_w)
      begin
        clk12_ff <= wbyte_w[0];
      end
      if (rf_we_w)
      begin
        run_ff <= wbyte_w[RF_RUN_CONTROL];
      end
    end
  end

  // Sticky flags: only software clears them and a hardware set wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ovf_ff <= 1'b0;
      evt_ff <= '0;
    end
    else if (rf_we_w)
    begin
      ovf_ff <= wbyte_w[RF_OVERFLOW_FLAG] || ovf_set_w;
      evt_ff <= wbyte_w[NUM_MODULES-1:0] | evt_set_w;
    end
    else
    begin
      ovf_ff <= ovf_ff || ovf_set_w;
      evt_ff <= evt_ff | evt_set_w;
    end
  end

  // Shared counter and prescaler; a bus write to the counter wins.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_ff <= RST_COUNT;
      pre_ff <= 4'h0;
    end
    else
    begin
      pre_ff <= (!run_w || src_w[1] || pre_done_w) ? 4'h0 : pre_ff + 4'h1;
      if (cnt_lo_we_w || cnt_hi_we_w)
      begin
        count_ff <= cnt_lo_we_w ? {count_ff[15:8], wbyte_w} : {wbyte_w, count_ff[7:0]};
      end
      else if (tick_w)
      begin
        count_ff <= nxt_count_w;
      end
    end
  end

  // Two-flop synchronisers and a third stage for edge detection.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_ff <= {NUM_MODULES{RST_PIN_LEVEL}}; // Idle pin level, so no false edge.
      pin_s2_ff <= {NUM_MODULES{RST_PIN_LEVEL}};
      pin_s3_ff <= {NUM_MODULES{RST_PIN_LEVEL}};
      eci_s1_ff <= 1'b0;
      eci_s2_ff <= 1'b0;
      eci_s3_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= module_pin_in;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      eci_s1_ff <= external_count_input;
      eci_s2_ff <= eci_s1_ff;
      eci_s3_ff <= eci_s2_ff;
    end
  end

  // Pins, interrupt and watchdog outputs.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_out_ff <= {NUM_MODULES{RST_PIN_LEVEL}};
      pin_oe_n_ff <= '1;
      irq_ff <= 1'b0;
      wdt_ff <= 1'b0;
    end
    else
    begin
      pin_out_ff <= nxt_pin;
      pin_oe_n_ff <= ~drive_w;
      irq_ff <= (ovf_ff && cfg_ff[CFG_OVF_IRQ_ENABLE]) || |(evt_ff & irq_en_w);
      wdt_ff <= cfg_ff[CFG_WATCHDOG_ENABLE] && match_w[WDT_MODULE];
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign module_pin_out = pin_out_ff;
  assign module_pin_oe_n = pin_oe_n_ff;
  assign irq = irq_ff;
  assign watchdog_reset = wdt_ff;

  // Checks on the counter, flags and pins.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire cnt_we_w = cnt_lo_we_w || cnt_hi_we_w;
  wire slow6_w = run_w && (src_w == SRC_OSC_SLOW) && !clk12_ff && !cfg_we_w && !clk_we_w;
  property p_ovf_set;
    ovf_set_w |=> ovf_ff && (count_ff == 16'h0000 || $past(cnt_we_w));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
  property p_ovf_sticky;
    ovf_ff && !rf_we_w |=> ovf_ff;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_evt_sticky;
    evt_ff[0] && !rf_we_w |=> evt_ff[0];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event flag lost");
  property p_stopped;
    (!run_ff || (cfg_ff[CFG_IDLE_STOP] && idle_mode)) && !cnt_we_w |=> $stable(count_ff);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");
  property p_div6;
    (tick_w && slow6_w) ##1 slow6_w[*6] |-> tick_w;
  endproperty
  a_div6: assert property (p_div6) else $error("slow source not one in six");
  property p_div6_gap;
    (tick_w && slow6_w) ##1 slow6_w |-> !tick_w;
  endproperty
  a_div6_gap: assert property (p_div6_gap) else $error("slow source ticked early");
  property p_capture;
    cap_w[0] |=> {vhi_ff[0], vlo_ff[0]} == $past(count_ff) && evt_ff[0];
  endproperty
  a_capture: assert property (p_capture) else $error("capture value or flag wrong");
  property p_toggle;
    match_w[2] && mode_ff[2][MM_TOGGLE] |=> pin_out_ff[2] != $past(pin_out_ff[2]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");
  property p_match_flag;
    match_w[2] && mode_ff[2][MM_FLAG_ON_MATCH] |=> evt_ff[2];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");
  property p_irq;
    evt_ff[0] && irq_en_w[0] |=> irq_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_pwm;
    mode_ff[0][MM_PWM] && mode_ff[0][MM_COMPARATOR_ENABLE] |=>
      pin_out_ff[0] == $past(pwm_lvl_w[0]) && !pin_oe_n_ff[0];
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm level wrong");
  c_overflow: cover property (ovf_set_w ##1 irq_ff);
  c_capture: cover property (cap_w[0] ##1 evt_ff[0]);
  c_toggle: cover property (match_w[2] && mode_ff[2][MM_TOGGLE]);
  c_watchdog: cover property (wdt_ff);

endmodule : programmable_counter_array

// *** test/pin_partner.sv ***
// Far side of the module pins and of the external count input.
module pin_partner
(
  input wire logic [4:0] drive_level,
  input wire logic count_level,
  input wire logic [4:0] module_pin_out,
  input wire logic [4:0] module_pin_oe_n,
  output logic [4:0] module_pin_in,
  output logic external_count_input
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each wire shows the block's level where the block drives it, else the far side's level.
  assign module_pin_in = (module_pin_oe_n & drive_level) | (~module_pin_oe_n & module_pin_out);
  // The count input is a plain level set by the far side.
  assign external_count_input = count_level;
endmodule : pin_partner

// *** test/tb.sv ***
module tb;
  import pca_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic idle_mode, timer0_overflow, count_level, external_count_input, irq, watchdog_reset;
  logic [4:0] drive_level, module_pin_in, module_pin_out, module_pin_oe_n;
  int miscompares, cmp_count, wd_pulses;

  programmable_counter_array uut
  (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .idle_mode, .timer0_overflow,
    .external_count_input, .module_pin_in, .module_pin_out, .module_pin_oe_n,
    .irq, .watchdog_reset
  );

  pin_partner far_side
  (
    .drive_level, .count_level, .module_pin_out, .module_pin_oe_n, .module_pin_in,
    .external_count_input
  );

  // The clock runs at 20 MHz.
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // Counts the watchdog pulses seen on the reset request.
  always @(posedge hclk)
  begin
    if (watchdog_reset === 1'b1)
      wd_pulses <= wd_pulses + 1;
  end

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  // Waits for the edge at which the slave shows ready, within a bound.
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 64)
      begin
        miscompares++;
        report_and_stop();
      end
      @(posedge hclk);
    end
  endtask : wait_ready

  // One single word transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    wait_ready();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(r, {24'h0, exp});
  endtask : rd_chk

  function automatic logic [7:0] at(input logic [7:0] base, input int n);
    return base + 8'(REG_STRIDE * n);
  endfunction : at

  task automatic set_count(input logic [15:0] v);
    wr(OFS_COUNT_LO, v[7:0]);
    wr(OFS_COUNT_HI, v[15:8]);
  endtask : set_count

  task automatic set_val(input int n, input logic [15:0] v);
    wr(at(OFS_VAL_LO_BASE, n), v[7:0]);
    wr(at(OFS_VAL_HI_BASE, n), v[15:8]);
  endtask : set_val

  task automatic cfg(input logic [1:0] src, input logic [7:0] extra);
    wr(OFS_MODE_CONFIG, extra | {5'h0, src, 1'b0});
  endtask : cfg

  task automatic tick(input int n);
    repeat (n)
    begin
      timer0_overflow <= 1'b1;
      @(posedge hclk);
      timer0_overflow <= 1'b0;
      @(posedge hclk);
    end
  endtask : tick

  // Ends a hung run.
  initial
  begin
    repeat (100000) @(posedge hclk);
    miscompares++;
    report_and_stop();
  end

  // Main sequence.
  initial
  begin
    logic [1:0] srcs [3];
    logic [3:0] divs [3];
    logic cms [3];
    int e;
    srcs = '{SRC_OSC_SLOW, SRC_OSC_FAST, SRC_OSC_SLOW};
    divs = '{DIV_SLOW_6CLK, DIV_FAST_6CLK, DIV_SLOW_12CLK};
    cms = '{1'b0, 1'b0, 1'b1};
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    idle_mode = 1'b0;
    timer0_overflow = 1'b0;
    count_level = 1'b0;
    drive_level = 5'h1f;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check({26'h0, hresp, module_pin_out & module_pin_oe_n}, 32'h1f);
    rd_chk(OFS_MODE_CONFIG, RST_REG8);
    rd_chk(OFS_RUN_FLAGS, RST_REG8);
    for (int n = 0; n < 5; n++)
      rd_chk(at(OFS_MODE_BASE, n), RST_REG8);
    rd_chk(8'h7c, 8'h00);
    wr(at(OFS_MODE_BASE, 0), 8'hff);
    rd_chk(at(OFS_MODE_BASE, 0), 8'h7f);
    set_count(16'habcd);
    rd_chk(OFS_COUNT_HI, 8'hab);
    // Internal oscillator sources counted over a fixed window.
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CLOCK_MODE, {7'h0, cms[i]});
      cfg(srcs[i], 8'h00);
      set_count(16'h0000);
      wr(OFS_RUN_FLAGS, 8'h40);
      cyc(120);
      wr(OFS_RUN_FLAGS, 8'h00);
      bus(1'b0, OFS_COUNT_LO, 8'h00, q);
      e = 120 / int'(divs[i]);
      check({31'h0, int'(q) >= e - 2 && int'(q) <= e + 2}, 32'h1);
      rd_chk(OFS_COUNT_LO, q[7:0]);
    end
    wr(OFS_CLOCK_MODE, 8'h00);
    // Timer-0 overflow pulses and external edges.
    cfg(SRC_TIMER0, 8'h00);
    set_count(16'h0000);
    wr(OFS_RUN_FLAGS, 8'h40);
    tick(5);
    cyc(2);
    rd_chk(OFS_COUNT_LO, 8'h05);
    cfg(SRC_EXT_PIN, 8'h00);
    repeat (3)
    begin
      count_level <= 1'b1;
      cyc(4);
      count_level <= 1'b0;
      cyc(4);
    end
    rd_chk(OFS_COUNT_LO, 8'h08);
    // Idle stop holds the counter while idle.
    wr(OFS_RUN_FLAGS, 8'h00);
    set_count(16'h0000);
    cfg(SRC_OSC_FAST, 8'h80);
    idle_mode <= 1'b1;
    wr(OFS_RUN_FLAGS, 8'h40);
    cyc(40);
    rd_chk(OFS_COUNT_LO, 8'h00);
    idle_mode <= 1'b0;
    cyc(40);
    bus(1'b0, OFS_COUNT_LO, 8'h00, q);
    check({31'h0, q != 32'h0}, 32'h1);
    // Overflow flag and its interrupt.
    wr(OFS_RUN_FLAGS, 8'h00);
    set_count(16'hfffe);
    cfg(SRC_OSC_FAST, 8'h01);
    wr(OFS_RUN_FLAGS, 8'h40);
    q = 32'h0;
    for (int i = 0; i < 20 && q[7] !== 1'b1; i++)
      bus(1'b0, OFS_RUN_FLAGS, 8'h00, q);
    check(q, 32'h0c0);
    check({31'h0, irq}, 32'h1);
    cyc(10);
    rd_chk(OFS_RUN_FLAGS, 8'hc0);
    wr(OFS_RUN_FLAGS, 8'h00);
    cyc(2);
    check({31'h0, irq}, 32'h0);
    // Captures on rising, falling and either edge with the counter stopped.
    cfg(SRC_TIMER0, 8'h00);
    wr(at(OFS_MODE_BASE, 0), 8'h21);
    wr(at(OFS_MODE_BASE, 1), 8'h10);
    wr(at(OFS_MODE_BASE, 3), 8'h30);
    set_count(16'h1111);
    drive_level <= 5'h00;
    cyc(8);
    rd_chk(OFS_RUN_FLAGS, 8'h0a);
    check({31'h0, irq}, 32'h0);
    rd_chk(at(OFS_VAL_LO_BASE, 1), 8'h11);
    set_count(16'h2222);
    drive_level <= 5'h1f;
    cyc(8);
    rd_chk(OFS_RUN_FLAGS, 8'h0b);
    check({31'h0, irq}, 32'h1);
    rd_chk(at(OFS_VAL_HI_BASE, 0), 8'h22);
    rd_chk(at(OFS_VAL_HI_BASE, 3), 8'h22);
    rd_chk(at(OFS_VAL_LO_BASE, 1), 8'h11);
    wr(OFS_RUN_FLAGS, 8'h00);
    rd_chk(OFS_RUN_FLAGS, 8'h00);
    // Compare matches on the shared counter, with and without the comparator.
    cfg(SRC_TIMER0, 8'h40);
    wr(at(OFS_MODE_BASE, 1), 8'h0c);
    wr(at(OFS_MODE_BASE, 2), 8'h4c);
    wr(at(OFS_MODE_BASE, 4), 8'h48);
    for (int n = 1; n < 5; n++)
      set_val(n, 16'h0010);
    set_count(16'h0000);
    wr(OFS_RUN_FLAGS, 8'h40);
    tick(16);
    cyc(6);
    rd_chk(OFS_RUN_FLAGS, 8'h54);
    check({30'h0, module_pin_oe_n[2:1]}, 32'h1);
    check({31'h0, module_pin_out[2]}, 32'h0);
    check(32'(wd_pulses), 32'h1);
    rd_chk(OFS_COUNT_HI, 8'h00);
    // Pulse width output follows the low counter byte against the value.
    wr(OFS_RUN_FLAGS, 8'h00);
    wr(at(OFS_MODE_BASE, 2), 8'h42);
    set_val(2, 16'h8080);
    set_count(16'h0090);
    cyc(4);
    check({30'h0, module_pin_out[2], module_pin_oe_n[2]}, 32'h2);
    set_count(16'h0010);
    cyc(4);
    check({31'h0, module_pin_out[2]}, 32'h0);
    cyc(2);
    report_and_stop();
  end
endmodule : tb
